//--- hw/sirq_pkg.sv
`default_nettype none
package sirq_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_STATUS  = 8'h00;
  localparam logic [7:0] OFF_IEN     = 8'h04;
  localparam logic [7:0] OFF_IFLAG   = 8'h08;
  localparam logic [7:0] OFF_FIFOCTL = 8'h0c;
  localparam logic [7:0] OFF_RWCTL   = 8'h10;

  // Field positions
  localparam int BIT_RW_ACTIVE  = 2;
  localparam int BIT_IRQ_PERIOD = 1;
  localparam int BIT_LINE_ONE   = 0;
  localparam int BIT_RW_IRQ     = 1;
  localparam int BIT_CARD_IRQ   = 0;
  localparam int ACCW_LO        = 3;
  localparam int ACCW_HI        = 4;
  localparam int BIT_THR        = 2;
  localparam int BIT_DIR        = 1;
  localparam int BIT_FRST       = 0;
  localparam int BIT_RWREQ      = 0;

  // Values after reset
  localparam logic [1:0] RST_IEN   = 2'h0;
  localparam logic [1:0] RST_FLAGS = 2'h0;
  localparam logic [1:0] RST_ACCW  = 2'h0;
  localparam logic       RST_BIT   = 1'h0;

  // Counts
  localparam logic [1:0] RW_START_DLY = 2'h2;
  localparam logic [2:0] ACC_MAX_BYTES = 3'h4;
  localparam logic [8:0] THR_BITS_LO  = 9'h080;
  localparam logic [8:0] THR_BITS_HI  = 9'h100;

  typedef enum logic [1:0] {RW_IDLE, RW_DELAY, RW_HOLD} sirq_rw_state_t;

  typedef struct packed {
    sirq_rw_state_t state;
    logic [1:0]     cnt;
    logic           active;
    logic           start;
    logic           lineOut;
    logic           lineOeN;
  } sirq_rw_regs_t;

endpackage
`default_nettype wire

//--- hw/sirq_rw_if.sv
`default_nettype none
interface sirq_rw_if;
  logic request;
  logic blockEnd;
  logic active;
  logic startPulse;
  modport ctrl   (output request, output blockEnd, input active, input startPulse);
  modport engine (input request, input blockEnd, output active, output startPulse);
endinterface
`default_nettype wire

//--- hw/sirq_read_wait.sv
`default_nettype none
module sirq_read_wait (
  // Clock and reset
  input  wire logic   clk,
  input  wire logic   rstSync_n,
  // Control link
  sirq_rw_if.engine   rw,
  // Data line two pin
  output var  logic   dat2Out,
  output var  logic   dat2OutEnable_n
);

  localparam sirq_pkg::sirq_rw_regs_t RESET_VAL = '{
    state: sirq_pkg::RW_IDLE, cnt: 2'h0, active: 1'b0,
    start: 1'b0, lineOut: 1'b0, lineOeN: 1'b1};

  sirq_pkg::sirq_rw_regs_t s_r;
  sirq_pkg::sirq_rw_regs_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.start = 1'b0;
    s_nxt.lineOut = 1'b0;
    case (s_r.state)
      sirq_pkg::RW_IDLE: begin
        if (rw.request && rw.blockEnd) begin
          s_nxt.state = sirq_pkg::RW_DELAY;
          s_nxt.cnt = sirq_pkg::RW_START_DLY - 2'h1;
        end
      end
      sirq_pkg::RW_DELAY: begin
        // Request withdrawn before start: no read wait at all
        if (!rw.request) begin
          s_nxt.state = sirq_pkg::RW_IDLE;
        end else if (s_r.cnt == 2'h0) begin
          s_nxt.state = sirq_pkg::RW_HOLD;
          s_nxt.active = 1'b1;
          s_nxt.start = 1'b1;
          s_nxt.lineOeN = 1'b0;
        end else begin
          s_nxt.cnt = s_r.cnt - 2'h1;
        end
      end
      sirq_pkg::RW_HOLD: begin
        if (!rw.request) begin
          s_nxt.state = sirq_pkg::RW_IDLE;
          s_nxt.active = 1'b0;
          s_nxt.lineOeN = 1'b1;
        end
      end
      default: begin
        s_nxt = RESET_VAL;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      s_r <= RESET_VAL;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rw.active = s_r.active;
  assign rw.startPulse = s_r.start;
  assign dat2Out = s_r.lineOut;
  assign dat2OutEnable_n = s_r.lineOeN;

  property p_rw_start_delay;
    @(posedge clk) disable iff (!rstSync_n)
    (s_r.state == sirq_pkg::RW_IDLE && rw.request && rw.blockEnd) ##1 rw.request
      ##1 rw.request |=> s_r.active && !dat2OutEnable_n && !dat2Out;
  endproperty
  a_rw_start_delay: assert property (p_rw_start_delay)
    else $error("read wait did not start two clocks after block end");

  property p_rw_not_early;
    @(posedge clk) disable iff (!rstSync_n)
    (s_r.state == sirq_pkg::RW_IDLE && rw.request && rw.blockEnd)
      |=> !s_r.active ##1 !s_r.active;
  endproperty
  a_rw_not_early: assert property (p_rw_not_early)
    else $error("read wait started too early");

  property p_rw_release;
    @(posedge clk) disable iff (!rstSync_n)
    (s_r.active && !rw.request) |=> !s_r.active && dat2OutEnable_n;
  endproperty
  a_rw_release: assert property (p_rw_release)
    else $error("data line two not released after request cleared");

endmodule
`default_nettype wire

//--- hw/sirq_top.sv
// Contract
// - Status bit 2 shows read wait active
// - Status bit 1 shows card interrupt period
// - Status bit 0 shows data line one
// - Enable bit 1 gates read-wait interrupt
// - Enable bit 0 gates card interrupt
// - Read-wait start sets flag 1 if enabled
// - Card interrupt detect sets flag 0 if enabled
// - Flags clear by writing one; zero keeps
// - Access width field bits 4-3 to FIFO
// - Bit 2 selects 128 or 256 bit threshold
// - Read wait starts two clocks after block
// - Bit 1 direction, bit 0 FIFO reset
//
// The placing of the registers and the address-and-strobe port were left to the implementer.
`default_nettype none
module sirq_top (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Register port
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWrData,
  input  wire logic        regWrEn,
  input  wire logic        regRdEn,
  output var  logic [31:0] regRdData,
  // Card bus side
  input  wire logic        dataLineOnePin,
  input  wire logic        cardIrqPeriod,
  input  wire logic        readBlockEnd,
  output var  logic        dat2Out,
  output var  logic        dat2OutEnable_n,
  // FIFO control
  output var  logic        fifoDirection,
  output var  logic        fifoStateReset,
  output var  logic [2:0]  accessBytes,
  output var  logic [8:0]  thresholdBits,
  // Interrupt
  output var  logic        sdioIrq
);

  typedef struct packed {
    logic [31:0] rdData;
    logic [1:0]  irqEn;
    logic [1:0]  flags;
    logic [1:0]  accWidth;
    logic        thrSel;
    logic        fifo_direction;
    logic        fifo_state_reset;
    logic        rwReq;
    logic        lineOne;
    logic        period;
    logic [2:0]  accBytes;
    logic [8:0]  thrBits;
    logic        irq;
  } sirq_top_regs_t;

  localparam sirq_top_regs_t RESET_VAL = '{
    rdData: 32'h0,
    irqEn: sirq_pkg::RST_IEN,
    flags: sirq_pkg::RST_FLAGS,
    accWidth: sirq_pkg::RST_ACCW,
    thrSel: sirq_pkg::RST_BIT,
    fifo_direction: sirq_pkg::RST_BIT,
    fifo_state_reset: sirq_pkg::RST_BIT,
    rwReq: sirq_pkg::RST_BIT,
    lineOne: 1'b0,
    period: 1'b0,
    accBytes: sirq_pkg::ACC_MAX_BYTES,
    thrBits: sirq_pkg::THR_BITS_LO,
    irq: 1'b0};

  // Width code 0 means the widest access
  function automatic logic [2:0] accBytesOf(input logic [1:0] code);
    accBytesOf = sirq_pkg::ACC_MAX_BYTES - {1'b0, code};
  endfunction

  function automatic logic [8:0] thrBitsOf(input logic sel);
    thrBitsOf = sel ? sirq_pkg::THR_BITS_HI : sirq_pkg::THR_BITS_LO;
  endfunction

  // Reset release through two flops
  logic [1:0] rstPipe;
  logic       rstSync_n;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstPipe <= 2'h0;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end

  assign rstSync_n = rstPipe[1];

  sirq_rw_if rwLink ();

  sirq_read_wait u_read_wait (
    .clk             (clk),
    .rstSync_n       (rstSync_n),
    .rw              (rwLink.engine),
    .dat2Out         (dat2Out),
    .dat2OutEnable_n (dat2OutEnable_n)
  );

  sirq_top_regs_t s_r;
  sirq_top_regs_t s_nxt;
  logic           cardDetect;
  logic           wrIflag;

  assign rwLink.request = s_r.rwReq;
  assign rwLink.blockEnd = readBlockEnd;

  // A card interrupt is detected when its period begins
  assign cardDetect = cardIrqPeriod && !s_r.period;
  assign wrIflag = regWrEn && (regAddr == sirq_pkg::OFF_IFLAG);

  function automatic logic [31:0] readMux(
    input logic [7:0]     addr,
    input sirq_top_regs_t st,
    input logic           rwActive
  );
    logic [31:0] v;
    v = 32'h0;
    case (addr)
      sirq_pkg::OFF_STATUS: begin
        v[sirq_pkg::BIT_RW_ACTIVE] = rwActive;
        v[sirq_pkg::BIT_IRQ_PERIOD] = st.period;
        v[sirq_pkg::BIT_LINE_ONE] = st.lineOne;
      end
      sirq_pkg::OFF_IEN: begin
        v[1:0] = st.irqEn;
      end
      sirq_pkg::OFF_IFLAG: begin
        v[1:0] = st.flags;
      end
      sirq_pkg::OFF_FIFOCTL: begin
        v[sirq_pkg::ACCW_HI:sirq_pkg::ACCW_LO] = st.accWidth;
        v[sirq_pkg::BIT_THR] = st.thrSel;
        v[sirq_pkg::BIT_DIR] = st.fifo_direction;
        v[sirq_pkg::BIT_FRST] = st.fifo_state_reset;
      end
      sirq_pkg::OFF_RWCTL: begin
        v[sirq_pkg::BIT_RWREQ] = st.rwReq;
      end
      default: begin
        v = 32'h0;
      end
    endcase
    readMux = v;
  endfunction

  always_comb begin
    s_nxt = s_r;
    s_nxt.rdData = 32'h0;
    // Pin levels are sampled once so every read sees a stable value
    s_nxt.lineOne = dataLineOnePin;
    s_nxt.period = cardIrqPeriod;
    if (regWrEn) begin
      case (regAddr)
        sirq_pkg::OFF_IEN: begin
          s_nxt.irqEn = regWrData[1:0];
        end
        sirq_pkg::OFF_IFLAG: begin
          s_nxt.flags = s_r.flags & ~regWrData[1:0];
        end
        sirq_pkg::OFF_FIFOCTL: begin
          s_nxt.accWidth = regWrData[sirq_pkg::ACCW_HI:sirq_pkg::ACCW_LO];
          s_nxt.thrSel = regWrData[sirq_pkg::BIT_THR];
          s_nxt.fifo_direction = regWrData[sirq_pkg::BIT_DIR];
          s_nxt.fifo_state_reset = regWrData[sirq_pkg::BIT_FRST];
        end
        sirq_pkg::OFF_RWCTL: begin
          s_nxt.rwReq = regWrData[sirq_pkg::BIT_RWREQ];
        end
        default: begin
          s_nxt.rwReq = s_r.rwReq;
        end
      endcase
    end
    // Sets come after the clear so an event in the clearing cycle survives
    if (rwLink.startPulse && s_r.irqEn[sirq_pkg::BIT_RW_IRQ]) begin
      s_nxt.flags[sirq_pkg::BIT_RW_IRQ] = 1'b1;
    end
    if (cardDetect && s_r.irqEn[sirq_pkg::BIT_CARD_IRQ]) begin
      s_nxt.flags[sirq_pkg::BIT_CARD_IRQ] = 1'b1;
    end
    if (regRdEn) begin
      s_nxt.rdData = readMux(regAddr, s_r, rwLink.active);
    end
    s_nxt.accBytes = accBytesOf(s_nxt.accWidth);
    s_nxt.thrBits = thrBitsOf(s_nxt.thrSel);
    // Flags only set when enabled, so the enables act as the mask
    s_nxt.irq = |s_nxt.flags;
  end

  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      s_r <= RESET_VAL;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign regRdData = s_r.rdData;
  assign fifoDirection = s_r.fifo_direction;
  assign fifoStateReset = s_r.fifo_state_reset;
  assign accessBytes = s_r.accBytes;
  assign thresholdBits = s_r.thrBits;
  assign sdioIrq = s_r.irq;

  property p_status_rw;
    @(posedge clk) disable iff (!rstSync_n)
    (regRdEn && regAddr == sirq_pkg::OFF_STATUS)
      |=> regRdData[2] == $past(rwLink.active) && regRdData[31:3] == 29'h0;
  endproperty
  a_status_rw: assert property (p_status_rw)
    else $error("status read does not show read wait activity");

  property p_status_period;
    @(posedge clk) disable iff (!rstSync_n)
    ##1 (regRdEn && regAddr == sirq_pkg::OFF_STATUS)
      |=> regRdData[1] == $past(cardIrqPeriod, 2);
  endproperty
  a_status_period: assert property (p_status_period)
    else $error("status read misses card interrupt period");

  property p_status_line_one;
    @(posedge clk) disable iff (!rstSync_n)
    ##1 (regRdEn && regAddr == sirq_pkg::OFF_STATUS)
      |=> regRdData[0] == $past(dataLineOnePin, 2);
  endproperty
  a_status_line_one: assert property (p_status_line_one)
    else $error("status read does not show data line one");

  property p_rw_flag_set;
    @(posedge clk) disable iff (!rstSync_n)
    (rwLink.startPulse && s_r.irqEn[1]) |=> s_r.flags[1] && sdioIrq;
  endproperty
  a_rw_flag_set: assert property (p_rw_flag_set)
    else $error("read wait flag not set on enabled start");

  property p_rw_flag_quiet;
    @(posedge clk) disable iff (!rstSync_n)
    (!s_r.flags[1] && !(rwLink.startPulse && s_r.irqEn[1])) |=> !s_r.flags[1];
  endproperty
  a_rw_flag_quiet: assert property (p_rw_flag_quiet)
    else $error("read wait flag set without enabled start");

  property p_card_flag_set;
    @(posedge clk) disable iff (!rstSync_n)
    (cardIrqPeriod && !s_r.period && s_r.irqEn[0]) |=> s_r.flags[0];
  endproperty
  a_card_flag_set: assert property (p_card_flag_set)
    else $error("card interrupt flag not set on enabled detect");

  property p_card_flag_quiet;
    @(posedge clk) disable iff (!rstSync_n)
    (!s_r.flags[0] && !s_r.irqEn[0]) |=> !s_r.flags[0];
  endproperty
  a_card_flag_quiet: assert property (p_card_flag_quiet)
    else $error("card interrupt flag set while disabled");

  property p_w1c;
    @(posedge clk) disable iff (!rstSync_n)
    (wrIflag && regWrData[0] && !cardDetect) |=> !s_r.flags[0];
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("writing one did not clear the flag");

  property p_w0_keep;
    @(posedge clk) disable iff (!rstSync_n)
    (wrIflag && !regWrData[1] && s_r.flags[1]) |=> s_r.flags[1];
  endproperty
  a_w0_keep: assert property (p_w0_keep)
    else $error("writing zero changed the flag");

  property p_fifo_ctl;
    @(posedge clk) disable iff (!rstSync_n)
    (regWrEn && regAddr == sirq_pkg::OFF_FIFOCTL && regWrData[4:3] == 2'h3 && regWrData[2])
      |=> accessBytes == 3'h1 && thresholdBits == 9'h100;
  endproperty
  a_fifo_ctl: assert property (p_fifo_ctl)
    else $error("FIFO width or threshold wrong after write");

  property p_fifo_dir;
    @(posedge clk) disable iff (!rstSync_n)
    (regWrEn && regAddr == sirq_pkg::OFF_FIFOCTL)
      |=> fifoDirection == $past(regWrData[1]) && fifoStateReset == $past(regWrData[0]);
  endproperty
  a_fifo_dir: assert property (p_fifo_dir)
    else $error("FIFO direction or reset not taken from write");

  property p_irq_level;
    @(posedge clk) disable iff (!rstSync_n)
    (s_r.flags != 2'h0) |-> sdioIrq;
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt output low while a flag is set");

  property p_irq_low;
    @(posedge clk) disable iff (!rstSync_n)
    (s_r.flags == 2'h0) |-> !sdioIrq;
  endproperty
  a_irq_low: assert property (p_irq_low)
    else $error("interrupt output high with no flag set");

  property p_rdata_idle;
    @(posedge clk) disable iff (!rstSync_n)
    !regRdEn |=> regRdData == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data present without a read");

  property p_ien_write;
    @(posedge clk) disable iff (!rstSync_n)
    (regWrEn && regAddr == sirq_pkg::OFF_IEN) |=> s_r.irqEn == $past(regWrData[1:0]);
  endproperty
  a_ien_write: assert property (p_ien_write)
    else $error("interrupt enables not taken from write");

  property p_rwreq_write;
    @(posedge clk) disable iff (!rstSync_n)
    (regWrEn && regAddr == sirq_pkg::OFF_RWCTL) |=> s_r.rwReq == $past(regWrData[0]);
  endproperty
  a_rwreq_write: assert property (p_rwreq_write)
    else $error("read wait request not taken from write");

  property p_w1c_rw;
    @(posedge clk) disable iff (!rstSync_n)
    (wrIflag && regWrData[1] && !rwLink.startPulse) |=> !s_r.flags[1];
  endproperty
  a_w1c_rw: assert property (p_w1c_rw)
    else $error("writing one did not clear the read wait flag");

  // A set flag must survive reads and unrelated writes
  property p_card_flag_sticky;
    @(posedge clk) disable iff (!rstSync_n)
    (s_r.flags[0] && !(wrIflag && regWrData[0])) |=> s_r.flags[0];
  endproperty
  a_card_flag_sticky: assert property (p_card_flag_sticky)
    else $error("card interrupt flag lost without a clear");

  property p_unmapped_rd;
    @(posedge clk) disable iff (!rstSync_n)
    (regRdEn && regAddr > sirq_pkg::OFF_RWCTL) |=> regRdData == 32'h0;
  endproperty
  a_unmapped_rd: assert property (p_unmapped_rd)
    else $error("unmapped read returned data");

endmodule
`default_nettype wire

//--- verification/sirq_card_model.sv
`default_nettype none
module sirq_card_model (
  // Clock
  input  wire logic clk,
  // Data line two from the host
  input  wire logic dat2Out,
  input  wire logic dat2OutEnable_n,
  // Lines toward the host
  output var  logic dataLineOnePin,
  output var  logic cardIrqPeriod,
  output var  logic readBlockEnd,
  output var  logic dat2Level
);
  timeunit 1ns;
  timeprecision 1ps;

  // Pull-up holds the line high once the host lets go
  assign dat2Level = dat2OutEnable_n ? 1'h1 : dat2Out;

  initial begin
    dataLineOnePin = 1'h1;
    cardIrqPeriod  = 1'h0;
    readBlockEnd   = 1'h0;
  end

  task automatic setLevels(input logic d1, input logic irq);
    @(posedge clk);
    dataLineOnePin <= d1;
    cardIrqPeriod  <= irq;
  endtask

  // One-cycle end of a read block; returns at the edge that samples it
  task automatic endBlock();
    @(posedge clk);
    readBlockEnd <= 1'h1;
    @(posedge clk);
    readBlockEnd <= 1'h0;
  endtask
endmodule
`default_nettype wire

//--- verification/tb_sdio_irq_status_fifo_control.sv
`default_nettype none
module tb_sdio_irq_status_fifo_control;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk;
  logic        rst_n;
  logic [7:0]  regAddr;
  logic [31:0] regWrData;
  logic        regWrEn;
  logic        regRdEn;
  logic [31:0] regRdData;
  logic        dataLineOnePin;
  logic        cardIrqPeriod;
  logic        readBlockEnd;
  logic        dat2Out;
  logic        dat2OutEnable_n;
  logic        fifoDirection;
  logic        fifoStateReset;
  logic [2:0]  accessBytes;
  logic [8:0]  thresholdBits;
  logic        sdioIrq;
  logic        dat2Level;
  logic [31:0] d;
  int          failures;
  int          checks;
  int          cyc;
  int          ienM, flagM, fifoM, reqM, rwActM, lineOneM, irqM;

  sirq_top sirq_top_inst (.clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .dataLineOnePin(dataLineOnePin), .cardIrqPeriod(cardIrqPeriod),
    .readBlockEnd(readBlockEnd), .dat2Out(dat2Out), .dat2OutEnable_n(dat2OutEnable_n),
    .fifoDirection(fifoDirection), .fifoStateReset(fifoStateReset),
    .accessBytes(accessBytes), .thresholdBits(thresholdBits), .sdioIrq(sdioIrq));

  sirq_card_model card_inst (.clk(clk), .dat2Out(dat2Out), .dat2OutEnable_n(dat2OutEnable_n),
    .dataLineOnePin(dataLineOnePin), .cardIrqPeriod(cardIrqPeriod),
    .readBlockEnd(readBlockEnd), .dat2Level(dat2Level));

  always #5 clk = ~clk;

  task automatic test_done();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Generous ceiling: the sequence needs well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      test_done();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  function automatic logic [31:0] mdl(input logic [7:0] a);
    case (a)
      sirq_pkg::OFF_STATUS:  return {29'h0, rwActM[0], irqM[0], lineOneM[0]};
      sirq_pkg::OFF_IEN:     return {30'h0, ienM[1:0]};
      sirq_pkg::OFF_IFLAG:   return {30'h0, flagM[1:0]};
      sirq_pkg::OFF_FIFOCTL: return {27'h0, fifoM[4:0]};
      sirq_pkg::OFF_RWCTL:   return {31'h0, reqM[0]};
      default:               return 32'h0;
    endcase
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] dd);
    @(posedge clk);
    regAddr   <= a;
    regWrData <= dd;
    regWrEn   <= 1'h1;
    @(posedge clk);
    regWrEn <= 1'h0;
    case (a)
      sirq_pkg::OFF_IEN:     ienM = dd[1:0];
      sirq_pkg::OFF_IFLAG:   flagM = flagM & ~int'(dd[1:0]);
      sirq_pkg::OFF_FIFOCTL: fifoM = dd[4:0];
      sirq_pkg::OFF_RWCTL:   reqM = dd[0];
      default: ;
    endcase
  endtask

  task automatic rd(input logic [7:0] a, input string nm);
    @(posedge clk);
    regAddr <= a;
    regRdEn <= 1'h1;
    @(posedge clk);
    regRdEn <= 1'h0;
    #1;
    chk(nm, regRdData, mdl(a));
  endtask

  initial begin
    clk = 1'h0;
    rst_n = 1'h0;
    regAddr = 8'h00;
    regWrData = 32'h0;
    regWrEn = 1'h0;
    regRdEn = 1'h0;
    ienM = 0;
    flagM = 0;
    fifoM = 0;
    reqM = 0;
    rwActM = 0;
    irqM = 0;
    lineOneM = 1;
    void'($urandom(84003));
    repeat (3) @(posedge clk);
    rst_n <= 1'h1;
    repeat (3) @(posedge clk);
    #1;
    chk("accessBytes", accessBytes, 32'h4);
    chk("thresholdBits", thresholdBits, 32'h80);
    chk("dat2 enable", dat2OutEnable_n, 32'h1);
    chk("irq", sdioIrq, 32'h0);
    for (int a = 0; a <= 'h14; a += 4) rd(a[7:0], "reset read");
    $display("test reset done");

    for (int i = 0; i < 8; i++) begin
      d = $urandom;
      d[4:3] = i[1:0];
      d[2] = i[2];
      wr(sirq_pkg::OFF_FIFOCTL, d);
      #1;
      chk("accessBytes", accessBytes, 32'(4 - i % 4));
      chk("thresholdBits", thresholdBits, d[2] ? 32'h100 : 32'h80);
      chk("fifoDirection", fifoDirection, d[1]);
      chk("fifoStateReset", fifoStateReset, d[0]);
      rd(sirq_pkg::OFF_FIFOCTL, "fifo ctl");
    end
    wr(8'h14, 32'hffffffff);
    wr(sirq_pkg::OFF_STATUS, 32'hffffffff);
    rd(8'h14, "unmapped");
    rd(sirq_pkg::OFF_FIFOCTL, "fifo ctl kept");
    $display("test fifo control done");

    for (int e = 0; e < 2; e++) begin
      lineOneM = $urandom & 1;
      irqM = 1;
      wr(sirq_pkg::OFF_IEN, 32'(e));
      card_inst.setLevels(lineOneM[0], 1'h1);
      repeat (2) @(posedge clk);
      rd(sirq_pkg::OFF_STATUS, "status");
      if (e == 1) flagM |= 1;
      irqM = 0;
      card_inst.setLevels(lineOneM[0], 1'h0);
      rd(sirq_pkg::OFF_IFLAG, "card flag");
      chk("irq", sdioIrq, 32'(flagM != 0));
    end
    wr(sirq_pkg::OFF_IFLAG, 32'h0);
    rd(sirq_pkg::OFF_IFLAG, "flag kept");
    wr(sirq_pkg::OFF_IFLAG, 32'h1);
    rd(sirq_pkg::OFF_IFLAG, "flag cleared");
    chk("irq", sdioIrq, 32'h0);
    $display("test card interrupt done");

    for (int e = 1; e >= 0; e--) begin
      wr(sirq_pkg::OFF_IEN, 32'(e << 1));
      wr(sirq_pkg::OFF_RWCTL, 32'h1);
      rd(sirq_pkg::OFF_RWCTL, "request");
      card_inst.endBlock();
      for (int k = 0; k < 3; k++) begin
        #1;
        chk("dat2 enable", dat2OutEnable_n, 32'(k < 2));
        if (k < 2) @(posedge clk);
      end
      chk("dat2 line", dat2Level, 32'h0);
      rwActM = 1;
      flagM |= e << 1;
      rd(sirq_pkg::OFF_STATUS, "rw status");
      rd(sirq_pkg::OFF_IFLAG, "rw flag");
      chk("irq", sdioIrq, 32'(flagM != 0));
      wr(sirq_pkg::OFF_RWCTL, 32'h0);
      rwActM = 0;
      repeat (2) @(posedge clk);
      #1;
      chk("dat2 released", dat2OutEnable_n, 32'h1);
      rd(sirq_pkg::OFF_STATUS, "rw ended");
      wr(sirq_pkg::OFF_IFLAG, 32'h3);
      rd(sirq_pkg::OFF_IFLAG, "rw flag cleared");
    end
    // Block end without a request must not start read wait
    card_inst.endBlock();
    repeat (3) @(posedge clk);
    #1;
    chk("dat2 idle", dat2OutEnable_n, 32'h1);
    $display("test read wait done");
    test_done();
  end
endmodule
`default_nettype wire
